// *** rtl/cpm_load_if.sv ***
`timescale 1ns/10ps
`default_nettype none

interface cpm_load_if;
	logic       start;
	logic       sda;
	logic       busy;
	logic       passed;
	logic       failed;
	logic       scl_drive;
	logic       lane_we;
	logic [2:0] lane_idx;
	logic [3:0] lane_data;

	modport ctl (output start, output sda, input busy, input passed, input failed,
		input scl_drive, input lane_we, input lane_idx, input lane_data);
	modport eng (input start, input sda, output busy, output passed, output failed,
		output scl_drive, output lane_we, output lane_idx, output lane_data);
endinterface : cpm_load_if

`default_nettype wire

// *** rtl/cpm_loader.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "cpm_regs.svh"

// Serial load engine: clocks the memory, checks the signature, fills lane settings
module cpm_loader (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	cpm_load_if.eng   lk
);
	typedef enum logic [2:0] {
		L_IDLE,
		L_LOW,
		L_HIGH,
		L_DONE,
		L_STALL
	} cpm_lstate_e;

	localparam logic [7:0] HALF = 8'(`CPM_SCL_HALF_CYC);

	cpm_lstate_e state;
	logic [7:0]  div;
	logic [2:0]  bit_cnt;
	logic [3:0]  byte_cnt;
	logic [7:0]  shift;
	logic        tick;
	logic        byte_end;
	logic [7:0]  next_shift;

	assign tick       = (div == HALF - 8'h01);
	assign byte_end   = (bit_cnt == 3'h7);
	assign next_shift = {shift[6:0], lk.sda};

	assign lk.busy      = (state == L_LOW) || (state == L_HIGH);
	assign lk.passed    = (state == L_DONE);
	assign lk.failed    = (state == L_STALL);
	assign lk.scl_drive = (state == L_LOW);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state        <= L_IDLE;
			div          <= 8'h00;
			bit_cnt      <= 3'h0;
			byte_cnt     <= 4'h0;
			shift        <= 8'h00;
			lk.lane_we   <= 1'b0;
			lk.lane_idx  <= 3'h0;
			lk.lane_data <= 4'h0;
		end else begin
			lk.lane_we <= 1'b0;
			div        <= (lk.busy && !tick) ? div + 8'h01 : 8'h00;
			unique case (state)
				L_IDLE: begin
					if (lk.start) begin
						state <= L_LOW;
					end
				end
				L_LOW: begin
					if (tick) begin
						state <= L_HIGH;
						shift <= next_shift;
					end
				end
				L_HIGH: begin
					if (tick) begin
						bit_cnt <= bit_cnt + 3'h1;
						state   <= L_LOW;
						if (byte_end) begin
							byte_cnt <= byte_cnt + 4'h1;
							if (byte_cnt == 4'h0 && shift != `CPM_LOAD_SIG) begin
								state <= L_STALL;
							end else if (byte_cnt != 4'h0) begin
								lk.lane_we   <= 1'b1;
								lk.lane_idx  <= 3'(byte_cnt - 4'h1);
								lk.lane_data <= {shift[5:4], shift[1:0]};
								if (byte_cnt == `CPM_LOAD_BYTES - 4'h1) begin
									state <= L_DONE;
								end
							end
						end
					end
				end
				L_DONE: state <= L_DONE;
				L_STALL: state <= L_STALL;
				default: state <= L_IDLE;
			endcase
		end
	end
endmodule : cpm_loader

`default_nettype wire

// *** rtl/cpm_pin_mode.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "cpm_regs.svh"

// Summary of operation
// - In master mode, a low on the load-request pin starts loading from the configuration memory.
// - After a load, the load-request pin is ignored; never threshold again.
// - Group equalization pins apply only in pin mode, one level per group.
// - In serial modes per-lane registers control every lane independently.
// - In serial modes the group-B equalization pin is slave address bit 3.
// - In pin mode a two-bit pin code sets group-B swing, unless overridden.
// - In serial modes the group-B swing pins are slave address bits 0 and 1.
// - Pin mode: group-A swing from pins, unless overridden; serial modes: those pins are SCL/SDA.
// - Threshold pin sets detect threshold in pin and slave modes; status only.
// - A failed load stalls forever; bus refused and done stays high.
// - In master mode load status is high while failed or incomplete, low once passed; other modes hold it low.
// - Master mode drives the clock pin during load, then releases it.
module cpm_pin_mode (
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	input  wire logic [1:0]  serial_config_enable,
	input  wire logic [1:0]  eq_level_group_a,
	input  wire logic [1:0]  eq_level_group_b,
	input  wire logic [1:0]  swing_sel_group_a0,
	input  wire logic [1:0]  swing_sel_group_a1,
	input  wire logic [1:0]  swing_sel_group_b0,
	input  wire logic [1:0]  swing_sel_group_b1,
	input  wire logic [1:0]  detect_threshold_sel,
	input  wire logic        slave_addr_bit2,
	input  wire logic        sda_in,
	input  wire logic [7:0]  signal_detect,
	output var  logic [15:0] eq_lane,
	output var  logic [15:0] swing_lane,
	output var  logic [3:0]  slave_addr_bits,
	output var  logic [1:0]  detect_threshold,
	output var  logic        load_not_done,
	output var  logic        scl_out,
	output var  logic        scl_oe,
	output var  logic        irq,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	// Strap level to a single address or code bit: float and high count as one
	function automatic logic lvl_bit(input logic [1:0] l);
		lvl_bit = (l == cpm_pkg::LVL_FLOAT) || (l == cpm_pkg::LVL_HIGH);
	endfunction : lvl_bit

	function automatic logic lane_hit(input logic [7:0] a);
		lane_hit = (a >= `CPM_REG_LANE_BASE) && (a <= `CPM_REG_LANE_LAST) && (a[1:0] == 2'h0);
	endfunction : lane_hit

	logic [1:0] rst_sync;
	logic       rst_n;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// Pad inputs cross into the clock domain
	logic [15:0] lvl_q;
	logic [9:0]  dig_q;

	cpm_sync #(.W(16)) u_lvl_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.din     ({serial_config_enable, eq_level_group_a, eq_level_group_b,
			swing_sel_group_a0, swing_sel_group_a1, swing_sel_group_b0,
			swing_sel_group_b1, detect_threshold_sel}),
		.dout    (lvl_q)
	);

	cpm_sync #(.W(10)) u_dig_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.din     ({slave_addr_bit2, sda_in, signal_detect}),
		.dout    (dig_q)
	);

	cpm_pkg::cpm_lvl_e lv_mode;
	cpm_pkg::cpm_lvl_e lv_eqa;
	cpm_pkg::cpm_lvl_e lv_eqb;
	cpm_pkg::cpm_lvl_e lv_thr;
	cpm_pkg::cpm_mode_e mode;
	logic [1:0] code_a;
	logic [1:0] code_b;
	logic       serial;
	logic       master;

	assign lv_mode = cpm_pkg::cpm_lvl_e'(lvl_q[15:14]);
	assign lv_eqa  = cpm_pkg::cpm_lvl_e'(lvl_q[13:12]);
	assign lv_eqb  = cpm_pkg::cpm_lvl_e'(lvl_q[11:10]);
	assign lv_thr  = cpm_pkg::cpm_lvl_e'(lvl_q[1:0]);
	assign code_a  = {lvl_bit(lvl_q[7:6]), lvl_bit(lvl_q[9:8])};
	assign code_b  = {lvl_bit(lvl_q[3:2]), lvl_bit(lvl_q[5:4])};
	assign mode    = (lv_mode == cpm_pkg::LVL_FLOAT) ? cpm_pkg::MODE_MASTER :
		(lv_mode == cpm_pkg::LVL_HIGH) ? cpm_pkg::MODE_SLAVE : cpm_pkg::MODE_PIN;
	assign serial  = (mode != cpm_pkg::MODE_PIN);
	assign master  = (mode == cpm_pkg::MODE_MASTER);

	// Load engine
	cpm_load_if lk ();
	logic load_start_seen;

	assign lk.start = master && !lvl_bit(lvl_q[1:0]) && !load_start_seen;
	assign lk.sda   = dig_q[8];

	cpm_loader u_loader (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.lk      (lk)
	);

	// Registers
	logic        ctrl_ovr;
	logic        sd_rb_en;
	logic [2:0]  int_stat;
	logic [2:0]  int_mask;
	logic [3:0]  lane_reg [`CPM_LANES];
	logic [7:0]  det_prev;
	logic [2:0]  int_evt;
	logic        passed_d;
	logic        failed_d;

	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        do_wr;
	logic        bus_blocked;
	logic        wr_ok;
	logic [2:0]  wr_lane;
	logic [7:0]  det_rb;
	logic [31:0] rd_word;
	logic        rd_ok;
	logic [2:0]  rd_lane;
	logic        w1c_hit;

	assign bus_blocked = lk.busy || lk.failed;
	assign do_wr   = aw_held && w_held && !s_axi_bvalid;
	assign wr_lane = aw_addr[4:2] - 3'h0;
	assign wr_ok   = !bus_blocked && (lane_hit(aw_addr) || aw_addr == `CPM_REG_CTRL ||
		aw_addr == `CPM_REG_SDCFG || aw_addr == `CPM_REG_INT_STAT ||
		aw_addr == `CPM_REG_INT_MASK || aw_addr == `CPM_REG_STATUS ||
		aw_addr == `CPM_REG_SDSTAT);
	assign w1c_hit = do_wr && wr_ok && w_strb[0] && (aw_addr == `CPM_REG_INT_STAT);
	assign det_rb  = sd_rb_en ? dig_q[7:0] : 8'h00;
	assign rd_lane = s_axi_araddr[4:2];
	assign int_evt = {sd_rb_en && (dig_q[7:0] != det_prev),
		lk.failed && !failed_d, lk.passed && !passed_d};

	always_comb begin
		rd_ok   = !bus_blocked;
		rd_word = 32'h0000_0000;
		if (lane_hit(s_axi_araddr)) begin
			rd_word = {26'h0, lane_reg[rd_lane][3:2], 2'h0, lane_reg[rd_lane][1:0]};
		end else if (s_axi_araddr == `CPM_REG_CTRL) begin
			rd_word = {31'h0, ctrl_ovr};
		end else if (s_axi_araddr == `CPM_REG_STATUS) begin
			rd_word = {18'h0, detect_threshold, slave_addr_bits, 3'h0,
				load_not_done, lk.failed, lk.busy, mode};
		end else if (s_axi_araddr == `CPM_REG_SDCFG) begin
			rd_word = {29'h0, sd_rb_en, 2'h0};
		end else if (s_axi_araddr == `CPM_REG_SDSTAT) begin
			rd_word = {24'h0, det_rb};
		end else if (s_axi_araddr == `CPM_REG_INT_STAT) begin
			rd_word = {29'h0, int_stat};
		end else if (s_axi_araddr == `CPM_REG_INT_MASK) begin
			rd_word = {29'h0, int_mask};
		end else begin
			rd_ok = 1'b0;
		end
	end

	// Write channel: address and data taken in either order
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `CPM_RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? `CPM_RESP_OKAY : `CPM_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
			end
		end
	end

	// Read channel
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `CPM_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_ok ? rd_word : 32'h0000_0000;
				s_axi_rresp  <= rd_ok ? `CPM_RESP_OKAY : `CPM_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Control registers, lane settings and interrupt status
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ovr <= `CPM_CTRL_RST;
			sd_rb_en <= `CPM_SDCFG_RST;
			int_mask <= `CPM_INT_MASK_RST;
			int_stat <= 3'h0;
			det_prev <= 8'h00;
			passed_d <= 1'b0;
			failed_d <= 1'b0;
			for (int i = 0; i < `CPM_LANES; i++) begin
				lane_reg[i] <= `CPM_LANE_RST;
			end
		end else begin
			det_prev <= dig_q[7:0];
			passed_d <= lk.passed;
			failed_d <= lk.failed;
			if (do_wr && wr_ok && w_strb[0]) begin
				if (aw_addr == `CPM_REG_CTRL) begin
					ctrl_ovr <= w_data[`CPM_CTRL_OVR_BIT];
				end
				if (aw_addr == `CPM_REG_SDCFG) begin
					sd_rb_en <= w_data[`CPM_SDCFG_RB_BIT];
				end
				if (aw_addr == `CPM_REG_INT_MASK) begin
					int_mask <= w_data[2:0];
				end
				if (lane_hit(aw_addr)) begin
					lane_reg[wr_lane] <= {w_data[`CPM_LANE_SWING_LSB +: 2],
						w_data[`CPM_LANE_EQ_LSB +: 2]};
				end
			end
			if (lk.lane_we) begin
				lane_reg[lk.lane_idx] <= lk.lane_data;
			end
			// Set wins over a simultaneous write-one clear
			int_stat <= (int_stat & ~(w1c_hit ? w_data[2:0] : 3'h0)) | int_evt;
		end
	end

	// Channel controls, address, threshold and pin outputs
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			eq_lane          <= 16'h0000;
			swing_lane       <= 16'h0000;
			slave_addr_bits  <= 4'h0;
			detect_threshold <= 2'h0;
			load_not_done    <= 1'b1;
			load_start_seen  <= 1'b0;
			scl_out          <= 1'b0;
			scl_oe           <= 1'b0;
			irq              <= 1'b0;
		end else begin
			for (int i = 0; i < `CPM_LANES; i++) begin
				if (serial || ctrl_ovr) begin
					eq_lane[2*i +: 2]    <= lane_reg[i][1:0];
					swing_lane[2*i +: 2] <= lane_reg[i][3:2];
				end else begin
					eq_lane[2*i +: 2]    <= (i < 4) ? lv_eqa : lv_eqb;
					swing_lane[2*i +: 2] <= (i < 4) ? code_a : code_b;
				end
			end
			if (serial) begin
				slave_addr_bits <= {lvl_bit(lv_eqb), dig_q[9],
					lvl_bit(lvl_q[5:4]), lvl_bit(lvl_q[3:2])};
			end else begin
				slave_addr_bits <= 4'h0;
			end
			if (!master && !load_start_seen) begin
				detect_threshold <= lv_thr;
			end
			if (lk.start) begin
				load_start_seen <= 1'b1;
			end
			load_not_done <= master ? !lk.passed : 1'b0;
			scl_out       <= 1'b0;
			scl_oe        <= lk.scl_drive;
			irq           <= |(int_stat & int_mask);
		end
	end
endmodule : cpm_pin_mode

`default_nettype wire

// *** rtl/cpm_pkg.sv ***
package cpm_pkg;

	// Resolved level of a four-level strap
	typedef enum logic [1:0] {
		LVL_LOW,
		LVL_RLOW,
		LVL_FLOAT,
		LVL_HIGH
	} cpm_lvl_e;

	typedef enum logic [1:0] {
		MODE_PIN,
		MODE_MASTER,
		MODE_SLAVE
	} cpm_mode_e;

endpackage : cpm_pkg

// *** rtl/cpm_regs.svh ***
`ifndef CPM_REGS_SVH
`define CPM_REGS_SVH

// Register byte offsets
`define CPM_REG_CTRL       8'h00
`define CPM_REG_STATUS     8'h04
`define CPM_REG_SDCFG      8'h08
`define CPM_REG_SDSTAT     8'h0C
`define CPM_REG_INT_STAT   8'h10
`define CPM_REG_INT_MASK   8'h14
`define CPM_REG_LANE_BASE  8'h20
`define CPM_REG_LANE_LAST  8'h3C

// Field positions
`define CPM_CTRL_OVR_BIT       0
`define CPM_SDCFG_RB_BIT       2
`define CPM_LANE_EQ_LSB        0
`define CPM_LANE_SWING_LSB     4
`define CPM_INT_PASS_BIT       0
`define CPM_INT_FAIL_BIT       1
`define CPM_INT_DET_BIT        2

// Reset values
`define CPM_CTRL_RST       1'h0
`define CPM_SDCFG_RST      1'h0
`define CPM_INT_MASK_RST   3'h0
`define CPM_LANE_RST       4'h0

// Configuration memory image
`define CPM_LOAD_SIG       8'hA5
`define CPM_LOAD_BYTES     4'h9
`define CPM_LANES          8

// Timing
`define CPM_CLK_NS         40
`define CPM_SCL_HALF_NS    5000
`define CPM_SCL_HALF_CYC   (`CPM_SCL_HALF_NS / `CPM_CLK_NS)

// Bus answers
`define CPM_RESP_OKAY      2'h0
`define CPM_RESP_SLVERR    2'h2

`endif

// *** rtl/cpm_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

// Three-stage synchroniser; a value is accepted once stages two and three agree
module cpm_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] agree;

	assign agree = ~(s2 ^ s3);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s1   <= '0;
			s2   <= '0;
			s3   <= '0;
			dout <= '0;
		end else begin
			s1   <= din;
			s2   <= s1;
			s3   <= s2;
			dout <= (agree & s3) | (~agree & dout);
		end
	end
endmodule : cpm_sync

`default_nettype wire

// *** tb/cpm_eeprom_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// Configuration memory: nine bytes MSB first on the clock the device pulls low
module cpm_eeprom_model (
	input  wire logic	rst_n,
	input  wire logic	scl_oe,
	input  wire logic	bad,
	input  wire logic [63:0]	img,
	output var  logic	sda
);
	int	n = 0;
	logic [7:0]	cur;
	assign cur = (n < 8) ? (bad ? 8'h5A : 8'hA5) : img[8*(n/8-1)+:8];

	// Data moves while the clock is low; after the frame the pull-up wins
	always @(posedge scl_oe or negedge scl_oe or negedge rst_n) begin
		if (!rst_n) begin
			n = 0;
			sda = 1'h1;
		end else if (scl_oe) begin
			if (n < 72) sda = cur[7 - n % 8];
		end else begin
			n = n + 1;
			if (n >= 72) sda = 1'h1;
		end
	end
endmodule : cpm_eeprom_model

`default_nettype wire

// *** tb/cpm_pin_mode_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none

module cpm_pin_mode_asserts (
	input wire logic	clk_sys,
	input wire logic	arst_n,
	input wire logic [1:0]	serial_config_enable,
	input wire logic [1:0]	eq_level_group_b,
	input wire logic [1:0]	swing_sel_group_b0,
	input wire logic [1:0]	swing_sel_group_b1,
	input wire logic [1:0]	detect_threshold_sel,
	input wire logic	slave_addr_bit2,
	input wire logic [3:0]	slave_addr_bits,
	input wire logic [1:0]	detect_threshold,
	input wire logic	load_not_done,
	input wire logic	scl_out,
	input wire logic	scl_oe,
	input wire logic	irq,
	input wire logic	s_axi_awvalid,
	input wire logic	s_axi_awready,
	input wire logic	s_axi_wvalid,
	input wire logic	s_axi_wready,
	input wire logic	s_axi_bvalid,
	input wire logic	s_axi_arvalid,
	input wire logic	s_axi_arready,
	input wire logic	s_axi_rvalid,
	input wire logic [1:0]	s_axi_rresp
);
	localparam int HALF = 125;
	logic [3:0]	settle;
	logic [7:0]	oe_run;
	wire logic [10:0]	straps;
	wire logic	ok;
	wire logic	mst;
	assign straps = {serial_config_enable, eq_level_group_b, swing_sel_group_b0,
		swing_sel_group_b1, detect_threshold_sel, slave_addr_bit2};
	assign ok = (settle == 4'hF);
	assign mst = (serial_config_enable == 2'h2);

	// Straps pass a synchroniser, so relations hold only once they stood still
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) settle <= 4'h0;
		else if (!$stable(straps)) settle <= 4'h0;
		else if (settle != 4'hF) settle <= settle + 4'h1;
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) oe_run <= 8'h0;
		else if (scl_oe) oe_run <= oe_run + 8'h1;
		else oe_run <= 8'h0;
	end

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	AST_ADDR_PIN: assert property (
		ok && !serial_config_enable[1] |-> slave_addr_bits == 4'h0)
		else $error("address bits not zero in pin mode");
	AST_ADDR_SERIAL: assert property (
		ok && serial_config_enable[1] |-> slave_addr_bits == {eq_level_group_b[1],
		slave_addr_bit2, swing_sel_group_b1[1], swing_sel_group_b0[1]})
		else $error("serial address bits wrong");
	AST_THRESHOLD: assert property (
		ok && !mst |-> detect_threshold == detect_threshold_sel)
		else $error("threshold does not follow its pin");
	AST_NO_LOAD: assert property (
		ok && !mst |-> !load_not_done && !scl_oe)
		else $error("load activity outside master mode");
	AST_SCL_OPEN_DRAIN: assert property (
		scl_out == 1'h0)
		else $error("clock pin driven high");
	AST_OE_HALF: assert property (
		$fell(scl_oe) |-> oe_run == HALF)
		else $error("clock low phase length wrong");
	AST_DONE_HOLD: assert property (
		ok && mst && !load_not_done |=> !load_not_done && !scl_oe)
		else $error("load restarted after completion");
	AST_BLOCKED: assert property (
		ok && mst && load_not_done && s_axi_rvalid |-> s_axi_rresp == 2'h2)
		else $error("bus answered while load not done");
	AST_READ_ANSWER: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_WRITE_ANSWER: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write answer late");

	cover property ($rose(scl_oe));
	cover property ($fell(load_not_done));
	cover property ($rose(irq));
endmodule : cpm_pin_mode_asserts

bind cpm_pin_mode cpm_pin_mode_asserts cpm_pin_mode_asserts_i (.*);

`default_nettype wire

// *** tb/cpm_pin_mode_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "cpm_regs.svh"

module cpm_pin_mode_bench;
	logic	clk_sys = 1'h0;
	logic	arst_n = 1'h0;
	logic [1:0]	serial_config_enable, eq_level_group_a, eq_level_group_b;
	logic [1:0]	swing_sel_group_a0, swing_sel_group_a1, swing_sel_group_b0;
	logic [1:0]	swing_sel_group_b1, detect_threshold_sel, detect_threshold;
	logic [1:0]	s_axi_bresp, s_axi_rresp;
	logic	slave_addr_bit2, sda_in, load_not_done, scl_out, scl_oe, irq, bad;
	logic [7:0]	signal_detect, s_axi_awaddr, s_axi_araddr;
	logic [15:0]	eq_lane, swing_lane, ee, es;
	logic [3:0]	slave_addr_bits, s_axi_wstrb;
	logic [31:0]	s_axi_wdata, s_axi_rdata, r;
	logic	s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic	s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [63:0]	img;
	logic [33:0]	rq[$];
	logic [1:0]	bq[$];
	int	failures = 0, comparisons = 0, cyc = 0, i;

	cpm_pin_mode cpm_pin_mode_i (.*);
	cpm_eeprom_model cpm_eeprom_model_i (.rst_n(arst_n), .scl_oe(scl_oe), .bad(bad),
		.img(img), .sda(sda_in));

	always #20 clk_sys = ~clk_sys;

	task end_of_test;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : end_of_test

	task cmp_val(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : cmp_val

	task cmp_rsp(input string n, input logic [33:0] e, input logic [33:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : cmp_rsp

	task rst(input logic [1:0] m, input logic [1:0] t);
		arst_n <= 1'h0;
		serial_config_enable <= m;
		detect_threshold_sel <= t;
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'h1;
		repeat (12) @(posedge clk_sys);
	endtask : rst

	task straps(input logic [31:0] v);
		{swing_sel_group_b1, swing_sel_group_b0, swing_sel_group_a1} <= v[11:6];
		{swing_sel_group_a0, eq_level_group_b, eq_level_group_a} <= v[5:0];
	endtask : straps

	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] p);
		bq.push_back(p);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_awvalid || s_axi_wvalid);
		while (!s_axi_bvalid) @(posedge clk_sys);
		s_axi_bready <= 1'h0;
		// Let an edge pass so a following call never reassigns bready in this step
		@(posedge clk_sys);
	endtask : wr

	task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] p);
		rq.push_back({p, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clk_sys); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		while (!s_axi_rvalid) @(posedge clk_sys);
		s_axi_rready <= 1'h0;
		// Let an edge pass so a following call never reassigns rready in this step
		@(posedge clk_sys);
	endtask : rd

	// Watches the bus answers and matches them against the oldest note
	always @(posedge clk_sys) begin
		cyc++;
		if (s_axi_bvalid && s_axi_bready)
			cmp_rsp("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
		if (s_axi_rvalid && s_axi_rready)
			cmp_rsp("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (cyc == 50000) begin
			failures++;
			end_of_test();
		end
	end

	initial begin
		r = $urandom(49916);
		{serial_config_enable, detect_threshold_sel, slave_addr_bit2, bad} = '0;
		{signal_detect, img, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		straps(32'h0);
		slave_addr_bit2 <= 1'h0;
		rst(2'h0, 2'h2);
		for (i = 0; i < 8; i++) begin
			r = (i < 4) ? {16{i[1:0]}} : $urandom;
			straps(r);
			serial_config_enable <= {1'h0, r[14]};
			detect_threshold_sel <= r[13:12];
			repeat (12) @(posedge clk_sys);
			ee = {{4{eq_level_group_b}}, {4{eq_level_group_a}}};
			es = {{4{swing_sel_group_b1[1], swing_sel_group_b0[1]}},
				{4{swing_sel_group_a1[1], swing_sel_group_a0[1]}}};
			cmp_val("eq_lane", ee, eq_lane);
			cmp_val("swing_lane", es, swing_lane);
			cmp_val("addr", 32'h0, slave_addr_bits);
			cmp_val("threshold", detect_threshold_sel, detect_threshold);
			cmp_val("load", 32'h0, {load_not_done, scl_oe});
		end
		wr(`CPM_REG_CTRL, 32'h1, `CPM_RESP_OKAY);
		wr(`CPM_REG_LANE_BASE, 32'h31, `CPM_RESP_OKAY);
		repeat (4) @(posedge clk_sys);
		cmp_val("override", 32'hD, {swing_lane[1:0], eq_lane[1:0]});
		rd(`CPM_REG_CTRL, 32'h1, `CPM_RESP_OKAY);
		rd(`CPM_REG_LANE_LAST, 32'h0, `CPM_RESP_OKAY);
		rd(8'h18, 32'h0, `CPM_RESP_SLVERR);
		wr(`CPM_REG_SDCFG, 32'h4, `CPM_RESP_OKAY);
		r = $urandom | 32'h1;
		signal_detect <= r[7:0];
		repeat (12) @(posedge clk_sys);
		rd(`CPM_REG_SDSTAT, {24'h0, r[7:0]}, `CPM_RESP_OKAY);
		rd(`CPM_REG_INT_STAT, 32'h4, `CPM_RESP_OKAY);
		cmp_val("irq", 32'h0, irq);
		wr(`CPM_REG_INT_MASK, 32'h4, `CPM_RESP_OKAY);
		repeat (3) @(posedge clk_sys);
		cmp_val("irq", 32'h1, irq);
		wr(`CPM_REG_INT_STAT, 32'h4, `CPM_RESP_OKAY);
		repeat (3) @(posedge clk_sys);
		cmp_val("irq", 32'h0, irq);
		rd(`CPM_REG_INT_STAT, 32'h0, `CPM_RESP_OKAY);
		$display("test pin_mode done");
		rst(2'h3, 2'h1);
		r = $urandom;
		straps(r);
		slave_addr_bit2 <= r[16];
		repeat (12) @(posedge clk_sys);
		cmp_val("addr", {eq_level_group_b[1], slave_addr_bit2, swing_sel_group_b1[1],
			swing_sel_group_b0[1]}, slave_addr_bits);
		cmp_val("threshold", 32'h1, detect_threshold);
		wr(`CPM_REG_LANE_BASE + 8'h14, 32'h12, `CPM_RESP_OKAY);
		repeat (4) @(posedge clk_sys);
		cmp_val("lanes", 32'h24, {eq_lane[11:10], swing_lane[11:10], eq_lane[1:0]});
		$display("test slave_mode done");
		img <= {$urandom, $urandom};
		rst(2'h2, 2'h0);
		cmp_val("load", 32'h1, load_not_done);
		rd(`CPM_REG_CTRL, 32'h0, `CPM_RESP_SLVERR);
		while (load_not_done) @(posedge clk_sys);
		repeat (4) @(posedge clk_sys);
		for (i = 0; i < 8; i++) begin
			ee[2*i+:2] = img[8*i+:2];
			es[2*i+:2] = img[8*i+4+:2];
		end
		cmp_val("eq_lane", ee, eq_lane);
		cmp_val("swing_lane", es, swing_lane);
		rd(`CPM_REG_INT_STAT, 32'h1, `CPM_RESP_OKAY);
		detect_threshold_sel <= 2'h3;
		repeat (20) @(posedge clk_sys);
		detect_threshold_sel <= 2'h0;
		repeat (300) @(posedge clk_sys);
		cmp_val("reload", 32'h0, {load_not_done, scl_oe});
		$display("test master_load done");
		bad <= 1'h1;
		rst(2'h2, 2'h0);
		repeat (19000) @(posedge clk_sys);
		cmp_val("load", 32'h1, load_not_done);
		rd(`CPM_REG_CTRL, 32'h0, `CPM_RESP_SLVERR);
		$display("test master_fail done");
		end_of_test();
	end
endmodule : cpm_pin_mode_bench

`default_nettype wire
